// ===== rtl/off_timer_pkg.sv
// package: register map, field layout, timing constants and types of the sink off timers
// Operation
// - zero code keeps sink lit while enabled
// - timed code darkens sink, then relights
// - code 1 is 0 s, +0.1 s per step
// - all-ones code holds sink dark until the sink is disabled
// - three 8-bit registers, field [6:0], bit7 reserved
// - zero on time: ramp down right after ramp up
package off_timer_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int NUM_SINKS = 3;
	// register offsets (sink 6 offset not printed; it sits just below sink 7)
	localparam logic [5:0] SINK6_OFF_TIME_ADDR = 6'h1e;
	localparam logic [5:0] SINK7_OFF_TIME_ADDR = 6'h1f;
	localparam logic [5:0] SINK8_OFF_TIME_ADDR = 6'h20;
	localparam logic [5:0] SINK_CTRL_ADDR = 6'h23;
	localparam logic [5:0] LIT_TIME_ADDR = 6'h24;
	localparam logic [5:0] FADE_TIME_ADDR = 6'h25;
	localparam logic [5:0] SINK_STATUS_ADDR = 6'h26;
	// field layout
	localparam int OFF_FIELD_MSB = 6;
	localparam int OFF_FIELD_W = 7;
	// reset values
	localparam logic [6:0] OFF_TIME_RST = 7'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] LIT_TIME_RST = 8'h00;
	localparam logic [7:0] FADE_TIME_RST = 8'h00;
	// special codes
	localparam logic [6:0] OFF_DISABLED = 7'h00;
	localparam logic [6:0] OFF_HOLD_DARK = 7'h7f;
	// timing: one off-time step is 0.1 s = 100 ms; on and fade steps 50 ms
	localparam int CLK_MHZ = 125;
	localparam int OFF_STEP_MS = 100;
	localparam int PHASE_STEP_MS = 50;
	localparam int OFF_STEP_CYC = OFF_STEP_MS * 1000 * CLK_MHZ;
	localparam int PHASE_STEP_CYC = PHASE_STEP_MS * 1000 * CLK_MHZ;
	// per-sink phase
	typedef enum logic [1:0] {
		PH_FADE_IN = 2'b00,
		PH_LIT = 2'b01,
		PH_FADE_OUT = 2'b11,
		PH_DARK = 2'b10
	} sink_phase_t;
	// register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// ===== rtl/led_sink_off_timer.sv
// module: off-time sequencer and register file for independent sinks 6, 7 and 8
`timescale 1ns/1ps
`default_nettype none
module led_sink_off_timer #(
	parameter int OFF_STEP = off_timer_pkg::OFF_STEP_CYC,
	parameter int PHASE_STEP = off_timer_pkg::PHASE_STEP_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// register port
	input wire off_timer_pkg::reg_req_t regReq,
	output logic [off_timer_pkg::DATA_W-1:0] regRdata,
	// sink drive: sinkLit high while sink is lit or ramping, sinkDark high while it is dark
	output logic [off_timer_pkg::NUM_SINKS-1:0] sinkLit,
	output logic [off_timer_pkg::NUM_SINKS-1:0] sinkDark
);
	import off_timer_pkg::*;

	// off-time field per sink
	logic [6:0] offTime_r [NUM_SINKS];
	// bit i enables sink 6+i
	logic [7:0] ctrl_r;
	// lit time steps (50 ms each)
	logic [7:0] litTime_r;
	// [7:4] fade-out steps, [3:0] fade-in steps
	logic [7:0] fadeTime_r;
	sink_phase_t phase_r [NUM_SINKS];
	logic [31:0] cycCnt_r [NUM_SINKS];
	logic [7:0] stepCnt_r [NUM_SINKS];
	logic [NUM_SINKS-1:0] held_r;
	logic [DATA_W-1:0] rdNxt;

	// steps a phase lasts; off code 1 means zero steps, each code above adds one
	function automatic logic [7:0] phaseSteps(input sink_phase_t ph, input logic [6:0] offCode,
		input logic [7:0] lit, input logic [7:0] fade);
		case (ph)
			PH_FADE_IN: phaseSteps = {4'h0, fade[3:0]};
			PH_LIT: phaseSteps = lit;
			PH_FADE_OUT: phaseSteps = {4'h0, fade[7:4]};
			default: phaseSteps = {1'b0, offCode - 7'd1};
		endcase
	endfunction

	// step length in clocks for a phase
	function automatic logic [31:0] stepLen(input sink_phase_t ph);
		stepLen = (ph == PH_DARK) ? 32'(OFF_STEP) : 32'(PHASE_STEP);
	endfunction

	// register writes; bit 7 of off timers is reserved and dropped
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM_SINKS; i++)
				offTime_r[i] <= OFF_TIME_RST;
			ctrl_r <= CTRL_RST;
			litTime_r <= LIT_TIME_RST;
			fadeTime_r <= FADE_TIME_RST;
		end
		else if (regReq.wr)
		begin
			unique case (regReq.addr)
				SINK6_OFF_TIME_ADDR: offTime_r[0] <= regReq.wdata[OFF_FIELD_MSB:0];
				SINK7_OFF_TIME_ADDR: offTime_r[1] <= regReq.wdata[OFF_FIELD_MSB:0];
				SINK8_OFF_TIME_ADDR: offTime_r[2] <= regReq.wdata[OFF_FIELD_MSB:0];
				SINK_CTRL_ADDR: ctrl_r <= regReq.wdata;
				LIT_TIME_ADDR: litTime_r <= regReq.wdata;
				FADE_TIME_ADDR: fadeTime_r <= regReq.wdata;
				default: ; // unmapped writes are ignored
			endcase
		end
	end

	// read mux; reserved bits and unmapped addresses read zero
	always_comb
	begin
		rdNxt = '0;
		unique case (regReq.addr)
			SINK6_OFF_TIME_ADDR: rdNxt = {1'b0, offTime_r[0]};
			SINK7_OFF_TIME_ADDR: rdNxt = {1'b0, offTime_r[1]};
			SINK8_OFF_TIME_ADDR: rdNxt = {1'b0, offTime_r[2]};
			SINK_CTRL_ADDR: rdNxt = ctrl_r;
			LIT_TIME_ADDR: rdNxt = litTime_r;
			FADE_TIME_ADDR: rdNxt = fadeTime_r;
			SINK_STATUS_ADDR: rdNxt = {2'b00, held_r, sinkLit};
			default: rdNxt = '0;
		endcase
	end

	// read data registered, stands one cycle after the strobe only
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			regRdata <= '0;
		else if (regReq.rd)
			regRdata <= rdNxt;
		else
			regRdata <= '0;
	end

	// per-sink phase sequencer
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM_SINKS; i++)
			begin
				phase_r[i] <= PH_FADE_IN;
				cycCnt_r[i] <= '0;
				stepCnt_r[i] <= '0;
				held_r[i] <= 1'b0;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_SINKS; i++)
			begin
				if (!ctrl_r[i])
				begin
					// disabled sink restarts from fade-in next time
					phase_r[i] <= PH_FADE_IN;
					cycCnt_r[i] <= '0;
					stepCnt_r[i] <= '0;
					held_r[i] <= 1'b0;
				end
				else if (held_r[i])
				begin
					// stays dark until disabled; rewriting the code does not relight
					held_r[i] <= 1'b1;
				end
				else if (offTime_r[i] == OFF_DISABLED)
				begin
					// no off phase: park in lit phase
					phase_r[i] <= PH_LIT;
					cycCnt_r[i] <= '0;
					stepCnt_r[i] <= '0;
				end
				else if (phase_r[i] == PH_DARK && offTime_r[i] == OFF_HOLD_DARK)
					held_r[i] <= 1'b1;
				else if (stepCnt_r[i] >= phaseSteps(phase_r[i], offTime_r[i], litTime_r, fadeTime_r))
				begin
					// phase done: advance; zero-length phases pass in one cycle
					cycCnt_r[i] <= '0;
					stepCnt_r[i] <= '0;
					unique case (phase_r[i])
						PH_FADE_IN: phase_r[i] <= PH_LIT;
						PH_LIT: phase_r[i] <= PH_FADE_OUT;
						PH_FADE_OUT: phase_r[i] <= PH_DARK;
						PH_DARK: phase_r[i] <= PH_FADE_IN;
					endcase
				end
				else if (cycCnt_r[i] == stepLen(phase_r[i]) - 32'd1)
				begin
					cycCnt_r[i] <= '0;
					stepCnt_r[i] <= stepCnt_r[i] + 8'd1;
				end
				else
					cycCnt_r[i] <= cycCnt_r[i] + 32'd1;
			end
		end
	end

	// sink outputs from flops; ramps count as lit
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sinkLit <= '0;
			sinkDark <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_SINKS; i++)
			begin
				sinkLit[i] <= ctrl_r[i] && !held_r[i] && (phase_r[i] != PH_DARK || offTime_r[i] == OFF_DISABLED);
				sinkDark[i] <= ctrl_r[i] && (held_r[i] || (phase_r[i] == PH_DARK && offTime_r[i] != OFF_DISABLED));
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/led_sink_off_timer_chk.sv
// checker: port-level properties of the sink off timers
`timescale 1ns/1ps
`default_nettype none
module led_sink_off_timer_chk #(
	parameter int OFF_STEP = 4
) (
	// clock, reset, register port and sink outputs
	input wire logic mclk,
	input wire logic rstn,
	input wire off_timer_pkg::reg_req_t regReq,
	input wire logic [7:0] regRdata,
	input wire logic [2:0] sinkLit,
	input wire logic [2:0] sinkDark
);
	import off_timer_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [6:0] code_r; // shadow of the sink 6 off code
	logic [1:0] wrHist_r; // outputs lag a write by two edges
	int darkCnt_r; // dark cycles, restarted by any write
	wire logic quiet = !regReq.wr && wrHist_r == 2'b00;
	wire logic offRd = regReq.rd && regReq.addr inside {[6'h1e:6'h20]};
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			code_r <= 7'h00;
			wrHist_r <= 2'b00;
			darkCnt_r <= 0;
		end
		else
		begin
			if (regReq.wr && regReq.addr == SINK6_OFF_TIME_ADDR)
				code_r <= regReq.wdata[6:0];
			wrHist_r <= {wrHist_r[0], regReq.wr};
			darkCnt_r <= (sinkDark[0] && !regReq.wr) ? darkCnt_r + 1 : 0;
		end
	property p_rsvd; offRd |=> !regRdata[7]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
	property p_back; regReq.rd && regReq.addr == SINK6_OFF_TIME_ADDR |=> regRdata == {1'b0, code_r}; endproperty
	a_back: assert property (p_back) else $error("readback");
	property p_idle; !regReq.rd |=> regRdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_excl; (sinkLit & sinkDark) == 3'b000; endproperty
	a_excl: assert property (p_excl) else $error("lit and dark");
	property p_stay; code_r == OFF_DISABLED && quiet && sinkLit[0] |=> sinkLit[0]; endproperty
	a_stay: assert property (p_stay) else $error("went dark");
	property p_hold; code_r == OFF_HOLD_DARK && quiet && sinkDark[0] |=> sinkDark[0]; endproperty
	a_hold: assert property (p_hold) else $error("released");
	property p_len; code_r inside {[7'h01:7'h7e]} && quiet |-> darkCnt_r <= (int'(code_r) - 1) * OFF_STEP + 2; endproperty
	a_len: assert property (p_len) else $error("dark too long");
	c_dark: cover property ($rose(sinkDark[0]));
	c_hold: cover property (code_r == OFF_HOLD_DARK && sinkDark[0]);
	c_read: cover property (offRd);
endmodule
bind led_sink_off_timer led_sink_off_timer_chk #(.OFF_STEP(OFF_STEP)) i_chk (.mclk(mclk), .rstn(rstn),
	.regReq(regReq), .regRdata(regRdata), .sinkLit(sinkLit), .sinkDark(sinkDark));
`default_nettype wire

// ===== bench/led_sink_off_timer_test.sv
// testbench: register access and off-phase timing of the sink off timers
`timescale 1ns/1ps
`default_nettype none
module led_sink_off_timer_test;
	import off_timer_pkg::*;
	localparam int OS = 4; // short off step keeps the run brief
	logic mclk = 0;
	logic rstn = 0;
	reg_req_t regReq = '0;
	logic [7:0] regRdata;
	logic [2:0] sinkLit;
	logic [2:0] sinkDark;
	int fails = 0;
	int samples_checked = 0;
	int n;
	int c;
	logic [7:0] d;
	led_sink_off_timer #(.OFF_STEP(OS), .PHASE_STEP(2)) i_dut (.mclk(mclk), .rstn(rstn), .regReq(regReq),
		.regRdata(regRdata), .sinkLit(sinkLit), .sinkDark(sinkDark));
	always #4 mclk = ~mclk;
	function automatic int darkLen(input int k);
		return (k - 1) * OS;
	endfunction
	task automatic chk(input bit ok, input string m);
		samples_checked++;
		if (!ok)
		begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic complete_run();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge mclk);
		regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		regReq <= '0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge mclk);
		regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		regReq <= '0;
		#1 chk(regRdata === e, "read data");
	endtask
	// bounded wait for sink 6 dark level v, n counts edges
	task automatic waitDark(input logic v);
		n = 0;
		// step off the launch edge so the registered level has settled
		#1;
		while (sinkDark[0] !== v)
		begin
			@(posedge mclk);
			#1 n++;
			if (n > 3000)
			begin
				chk(1'b0, "wait");
				complete_run();
			end
		end
	endtask
	initial
	begin
		void'($urandom(32'hf1f9_acdb));
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			d = 8'($urandom()) | 8'h80;
			rd(6'h1e + 6'(i), 8'h00);
			wr(6'h1e + 6'(i), d);
			rd(6'h1e + 6'(i), {1'b0, d[6:0]});
		end
		rd(6'h3f, 8'h00);
		wr(LIT_TIME_ADDR, 8'h00);
		wr(FADE_TIME_ADDR, 8'h11);
		wr(SINK6_OFF_TIME_ADDR, 8'h00);
		wr(SINK_CTRL_ADDR, 8'h07);
		repeat (40) @(posedge mclk);
		#1 chk(sinkLit[0] === 1'b1 && sinkDark[0] === 1'b0, "steady lit");
		for (int i = 0; i < 4; i++)
		begin
			c = (i < 2) ? i + 1 : 2 + $urandom_range(18);
			wr(SINK6_OFF_TIME_ADDR, 8'(c));
			waitDark(1'b1);
			waitDark(1'b0);
			chk(n >= darkLen(c) && n <= darkLen(c) + 2, "dark length");
			@(posedge mclk);
			#1 chk(sinkLit[0] === 1'b1, "relit");
		end
		wr(SINK6_OFF_TIME_ADDR, 8'h7f);
		waitDark(1'b1);
		repeat (100) @(posedge mclk);
		#1 chk(sinkDark[0] === 1'b1 && sinkLit[0] === 1'b0, "held dark");
		wr(SINK_CTRL_ADDR, 8'h00);
		repeat (3) @(posedge mclk);
		#1 chk(sinkLit === 3'b000 && sinkDark === 3'b000, "disabled");
		complete_run();
	end
endmodule
`default_nettype wire
